// [inc/external_space_ram_pkg.sv]
package external_space_ram_pkg;
    // ram geometry
    localparam int RAM_BYTES = 512;
    localparam int RAM_ADDR_W = 9;
    localparam int PAGE_BIT_POS = 0;
    // wishbone register map, byte addresses (printed offset times four)
    localparam logic [7:0] PAGE_REG_INDEX = 8'hAA;
    localparam logic [11:0] PAGE_REG_ADDR = {2'h0, PAGE_REG_INDEX, 2'h0};
    localparam logic [11:0] STATUS_REG_ADDR = 12'h400;
    localparam logic [7:0] PAGE_REG_RESET = 8'h00;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
    // cpu-side external move request
    typedef struct packed {
        logic req;
        logic write;
        logic indirect8;
        logic [15:0] addr;
        logic [7:0] wdata;
    } move_req_type;
endpackage

// [hw/external_space_ram_store.sv]
`timescale 1ns/1ps
module external_space_ram_store (
    input wire logic i_clk,
    input wire logic i_we,
    input wire logic [8:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata
);
    // synchronous byte ram, read data one cycle after address
    logic [7:0] mem [0:external_space_ram_pkg::RAM_BYTES-1];

    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_addr] <= i_wdata;
        end
        o_rdata <= mem[i_addr];
    end
endmodule

// [hw/external_space_ram_address_mapper.sv]
// Added by the designer: the Wishbone slave port.
`timescale 1ns/1ps
module external_space_ram_address_mapper (
    input wire logic i_clk,
    input wire logic i_reset,
    // cpu external move port
    input wire external_space_ram_pkg::move_req_type i_move,
    input wire logic i_flash_write_sel,
    output logic o_move_ack,
    output logic [7:0] o_move_rdata,
    output logic [8:0] o_ram_addr,
    // wishbone slave
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [11:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack
);
    // page select bit, the only stored bit of the page register
    logic page_reg;
    logic [8:0] ram_addr_next;
    logic ram_we;
    logic [7:0] ram_rdata;
    logic move_pend_reg;
    logic last_was_indirect_reg;
    logic [15:0] move_count_reg;
    logic move_take;
    logic page_wr;
    logic wb_rd_take;

    // effective address: indirect uses page bit as address bit 8
    function automatic logic [8:0] map_addr(input logic indirect8, input logic pg,
                                           input logic [15:0] a);
        if (indirect8) begin
            map_addr = {pg, a[7:0]};
        end else begin
            map_addr = a[external_space_ram_pkg::RAM_ADDR_W-1:0];
        end
    endfunction

    // flash writes are steered away; everything else hits the ram
    // a move is never taken again at its own ack edge, the cpu still holds it there
    always_comb begin
        ram_addr_next = map_addr(i_move.indirect8, page_reg, i_move.addr);
        move_take = i_move.req && !i_flash_write_sel && !move_pend_reg && !o_move_ack;
        ram_we = move_take && i_move.write;
        page_wr = i_wb_cyc && i_wb_stb && o_wb_ack && i_wb_we && i_wb_sel[0]
                  && (i_wb_adr == external_space_ram_pkg::PAGE_REG_ADDR);
        wb_rd_take = i_wb_cyc && i_wb_stb && !o_wb_ack && !i_wb_we;
    end

    external_space_ram_store store_i (
        .i_clk(i_clk),
        .i_we(ram_we),
        .i_addr(ram_addr_next),
        .i_wdata(i_move.wdata),
        .o_rdata(ram_rdata)
    );

    // one move per request; ack two cycles after the take, with read data
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            move_pend_reg <= 1'b0;
            o_move_ack <= 1'b0;
            o_ram_addr <= 9'h000;
        end else begin
            move_pend_reg <= move_take;
            o_move_ack <= move_pend_reg;
            if (move_take) begin
                o_ram_addr <= ram_addr_next;
            end
        end
    end

    // read data registered so the output is a flop
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_move_rdata <= 8'h00;
        end else if (move_pend_reg) begin
            o_move_rdata <= ram_rdata;
        end
    end

    // activity counters, visible in the status register
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            move_count_reg <= 16'h0000;
            last_was_indirect_reg <= 1'b0;
        end else if (move_take) begin
            move_count_reg <= move_count_reg + 16'h0001;
            last_was_indirect_reg <= i_move.indirect8;
        end
    end

    // wishbone: ack one cycle after request, dropped the following cycle
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h0000_0000;
        end else begin
            o_wb_ack <= i_wb_cyc && i_wb_stb && !o_wb_ack;
            if (wb_rd_take) begin
                case (i_wb_adr)
                    external_space_ram_pkg::PAGE_REG_ADDR: o_wb_dat <= {31'h0, page_reg};
                    external_space_ram_pkg::STATUS_REG_ADDR: o_wb_dat <= {15'h0, last_was_indirect_reg,
                                                            move_count_reg};
                    default: o_wb_dat <= external_space_ram_pkg::UNMAPPED_READ;
                endcase
            end
        end
    end

    // page register write, lane 0 only; upper bits discarded
    // lands at the ack edge, while the master still holds the request
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            page_reg <= external_space_ram_pkg::PAGE_REG_RESET[external_space_ram_pkg::PAGE_BIT_POS];
        end else if (page_wr) begin
            page_reg <= i_wb_dat[external_space_ram_pkg::PAGE_BIT_POS];
        end
    end

    // indirect move address uses the page bit
    indirect_page_a: assert property (@(posedge i_clk) disable iff (i_reset)
        (move_take && i_move.indirect8)
        |=> o_ram_addr == {$past(page_reg), $past(i_move.addr[7:0])})
        else $error("indirect address page mismatch");
    pointer_fold_a: assert property (@(posedge i_clk) disable iff (i_reset)
        (move_take && !i_move.indirect8)
        |=> o_ram_addr == $past(i_move.addr[8:0]))
        else $error("pointer address not folded to nine bits");
    move_ack_a: assert property (@(posedge i_clk) disable iff (i_reset)
        move_take |-> ##2 o_move_ack)
        else $error("move not acknowledged in two cycles");
    flash_skip_a: assert property (@(posedge i_clk) disable iff (i_reset)
        i_flash_write_sel |=> !move_pend_reg)
        else $error("flash-routed move reached ram");
    page_read_a: assert property (@(posedge i_clk) disable iff (i_reset)
        (o_wb_ack && $past(!i_wb_we) && $past(i_wb_adr) == external_space_ram_pkg::PAGE_REG_ADDR)
        |-> o_wb_dat[31:1] == 31'h0)
        else $error("page register upper bits not zero");
    ram_mirror_a: assert property (@(posedge i_clk) disable iff (i_reset)
        !i_move.indirect8 |-> ram_addr_next == 9'(i_move.addr % 16'(external_space_ram_pkg::RAM_BYTES)))
        else $error("ram address outside 512 bytes");
    ram_write_a: assert property (@(posedge i_clk) disable iff (i_reset)
        ram_we |=> move_pend_reg ##1 o_move_ack)
        else $error("ram write not followed by ack");
    wb_ack_a: assert property (@(posedge i_clk) disable iff (i_reset)
        o_wb_ack |=> !o_wb_ack)
        else $error("wishbone ack held two cycles");

    // move handshake: ack is a single pulse after the pending cycle
    move_ack_pulse_a: assert property (@(posedge i_clk) disable iff (i_reset)
        o_move_ack |=> !o_move_ack)
        else $error("move ack held two cycles");
    // ack never appears without a pending move before it
    ack_after_pend_a: assert property (@(posedge i_clk) disable iff (i_reset)
        o_move_ack |-> $past(move_pend_reg))
        else $error("move ack without pending move");
    // pending lasts one cycle only
    pend_single_a: assert property (@(posedge i_clk) disable iff (i_reset)
        move_pend_reg |=> !move_pend_reg)
        else $error("pending move held two cycles");
    // pending only ever comes from a taken move
    pend_from_take_a: assert property (@(posedge i_clk) disable iff (i_reset)
        move_pend_reg |-> $past(move_take))
        else $error("pending move without a take");
    // a held request must not be taken a second time at its ack
    no_retake_a: assert property (@(posedge i_clk) disable iff (i_reset)
        o_move_ack |-> !ram_we)
        else $error("ram written again at ack");
    // read byte handed over with the ack is the one the ram gave
    rdata_with_ack_a: assert property (@(posedge i_clk) disable iff (i_reset)
        o_move_ack |-> o_move_rdata == $past(ram_rdata))
        else $error("move read data not from ram");
    // read byte stands until the next pending cycle
    rdata_hold_a: assert property (@(posedge i_clk) disable iff (i_reset)
        !move_pend_reg |=> $stable(o_move_rdata))
        else $error("move read data changed without a move");
    // effective address only moves when a move is taken
    addr_hold_a: assert property (@(posedge i_clk) disable iff (i_reset)
        !move_take |=> $stable(o_ram_addr))
        else $error("ram address changed without a move");
    // flash-routed moves never write the ram
    flash_no_write_a: assert property (@(posedge i_clk) disable iff (i_reset)
        i_flash_write_sel |-> !ram_we)
        else $error("flash move wrote the ram");
    // flash-routed moves are never acknowledged here
    flash_no_ack_a: assert property (@(posedge i_clk) disable iff (i_reset)
        i_flash_write_sel && !move_pend_reg && !o_move_ack |=> ##1 !o_move_ack)
        else $error("flash move acknowledged");
    // indirect high address bit is the page bit
    indirect_high_a: assert property (@(posedge i_clk) disable iff (i_reset)
        i_move.indirect8 |-> ram_addr_next[8] == page_reg)
        else $error("indirect high bit not from page");
    // indirect low byte is the operand
    indirect_low_a: assert property (@(posedge i_clk) disable iff (i_reset)
        i_move.indirect8 |-> ram_addr_next[7:0] == i_move.addr[7:0])
        else $error("indirect low byte not from operand");
    // move counter steps once per taken move
    count_step_a: assert property (@(posedge i_clk) disable iff (i_reset)
        move_take |=> move_count_reg == $past(move_count_reg) + 16'h0001)
        else $error("move count did not step");
    // move counter stands between moves
    count_hold_a: assert property (@(posedge i_clk) disable iff (i_reset)
        !move_take |=> $stable(move_count_reg))
        else $error("move count changed without a move");
    // wishbone: every new request is answered one cycle later
    wb_ack_next_a: assert property (@(posedge i_clk) disable iff (i_reset)
        (i_wb_cyc && i_wb_stb && !o_wb_ack) |=> o_wb_ack)
        else $error("wishbone request not acknowledged");
    // wishbone: no ack without a request before it
    wb_ack_req_a: assert property (@(posedge i_clk) disable iff (i_reset)
        o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
        else $error("wishbone ack without request");
    // read data stands until the next read is taken
    wb_dat_hold_a: assert property (@(posedge i_clk) disable iff (i_reset)
        !wb_rd_take |=> $stable(o_wb_dat))
        else $error("wishbone read data changed without read");
    // page write lands with the written bit 0
    page_write_a: assert property (@(posedge i_clk) disable iff (i_reset)
        page_wr |=> page_reg == $past(i_wb_dat[external_space_ram_pkg::PAGE_BIT_POS]))
        else $error("page register write lost");
    // page bit stands without a write
    page_hold_a: assert property (@(posedge i_clk) disable iff (i_reset)
        !page_wr |=> $stable(page_reg))
        else $error("page register changed without write");
    // unmapped reads return the fixed filler
    unmapped_read_a: assert property (@(posedge i_clk) disable iff (i_reset)
        (o_wb_ack && $past(!i_wb_we) && $past(i_wb_adr) != external_space_ram_pkg::PAGE_REG_ADDR
         && $past(i_wb_adr) != external_space_ram_pkg::STATUS_REG_ADDR)
        |-> o_wb_dat == external_space_ram_pkg::UNMAPPED_READ)
        else $error("unmapped read not zero");
    // status upper bits read as zero
    status_read_a: assert property (@(posedge i_clk) disable iff (i_reset)
        (o_wb_ack && $past(!i_wb_we) && $past(i_wb_adr) == external_space_ram_pkg::STATUS_REG_ADDR)
        |-> o_wb_dat[31:17] == 15'h0000)
        else $error("status upper bits not zero");
    // reset leaves every output and the page bit cleared
    reset_clear_a: assert property (@(posedge i_clk)
        $past(i_reset) |-> !o_move_ack && !o_wb_ack && !page_reg
                           && o_ram_addr == 9'h000 && !move_pend_reg)
        else $error("state not cleared by reset");
endmodule

// [bench/cpu_move_model.sv]
`timescale 1ns/1ps
module cpu_move_model (
    input wire logic i_clk,
    input wire logic i_move_ack,
    input wire logic [7:0] i_move_rdata,
    output external_space_ram_pkg::move_req_type o_move
);
    initial o_move = '0;
    // one move held until ack; an idle edge always precedes the next request
    task automatic move(input logic wr, input logic ind, input logic [15:0] a,
                        input logic [7:0] d, output logic [7:0] q);
        @(posedge i_clk);
        o_move <= {1'b1, wr, ind, a, d};
        do @(posedge i_clk); while (i_move_ack !== 1'b1);
        q = i_move_rdata;
        o_move <= '0;
    endtask
    // flash-routed write: held a few cycles, reports whether any ack came
    task automatic probe(input logic [15:0] a, input logic [7:0] d, output logic seen);
        seen = 1'b0;
        @(posedge i_clk);
        o_move <= {1'b1, 1'b1, 1'b0, a, d};
        repeat (4) begin
            @(posedge i_clk);
            if (i_move_ack !== 1'b0) seen = 1'b1;
        end
        o_move <= '0;
    endtask
endmodule

// [bench/external_space_ram_address_mapper_test.sv]
`timescale 1ns/1ps
module external_space_ram_address_mapper_test;
    logic i_clk = 0, i_reset = 1, wb_req = 0, we = 0, flash_sel = 0, seen;
    logic [11:0] adr = '0;
    logic [31:0] wdat = '0, o_wb_dat, q;
    logic [7:0] o_move_rdata, b;
    logic [8:0] o_ram_addr;
    logic o_move_ack, o_wb_ack;
    external_space_ram_pkg::move_req_type mv;
    int failures = 0, compares = 0, cycles = 0;
    initial forever #50 i_clk = ~i_clk;
    external_space_ram_address_mapper external_space_ram_address_mapper_i (.i_clk(i_clk), .i_reset(i_reset),
        .i_move(mv), .i_flash_write_sel(flash_sel), .o_move_ack(o_move_ack),
        .o_move_rdata(o_move_rdata), .o_ram_addr(o_ram_addr), .i_wb_cyc(wb_req),
        .i_wb_stb(wb_req), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF),
        .i_wb_dat(wdat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack));
    cpu_move_model cpu_move_model_i (.i_clk(i_clk), .i_move_ack(o_move_ack),
        .i_move_rdata(o_move_rdata), .o_move(mv));
    // classic cycle: hold until ack is sampled, then release
    task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge i_clk);
        wb_req <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge i_clk); while (o_wb_ack !== 1'b1);
        q = o_wb_dat;
        wb_req <= 1'b0;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // hang guard, well above the sixty-four cycles the tests need
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures++;
            stop_test();
        end
    end
    initial begin
        repeat (12) @(posedge i_clk);
        i_reset <= 1'b0;
        wb(1'b0, external_space_ram_pkg::PAGE_REG_ADDR, 32'h0);
        check(q, 32'h0);
        wb(1'b1, external_space_ram_pkg::PAGE_REG_ADDR, 32'hFF);
        wb(1'b0, external_space_ram_pkg::PAGE_REG_ADDR, 32'h0);
        check(q, 32'h1);
        wb(1'b0, 12'h004, 32'h0);
        check(q, external_space_ram_pkg::UNMAPPED_READ);
        $display("register test done");
        cpu_move_model_i.move(1'b1, 1'b0, 16'h0005, 8'hA5, b);
        cpu_move_model_i.move(1'b0, 1'b0, 16'h0205, 8'h00, b);
        check(32'(b), 32'hA5);
        cpu_move_model_i.move(1'b0, 1'b0, 16'hFE05, 8'h00, b);
        check(32'(b), 32'hA5);
        check(32'(o_ram_addr), 32'h005);
        $display("pointer alias test done");
        cpu_move_model_i.move(1'b1, 1'b1, 16'hFF33, 8'h3C, b);
        cpu_move_model_i.move(1'b0, 1'b0, 16'h0133, 8'h00, b);
        check(32'(b), 32'h3C);
        cpu_move_model_i.move(1'b1, 1'b0, 16'h01FF, 8'h5A, b);
        cpu_move_model_i.move(1'b0, 1'b1, 16'h00FF, 8'h00, b);
        check(32'(b), 32'h5A);
        check(32'(o_ram_addr), 32'h1FF);
        $display("paged indirect test done");
        flash_sel <= 1'b1;
        cpu_move_model_i.probe(16'h0005, 8'h77, seen);
        flash_sel <= 1'b0;
        check(32'(seen), 32'h0);
        cpu_move_model_i.move(1'b0, 1'b0, 16'h0005, 8'h00, b);
        check(32'(b), 32'hA5);
        wb(1'b0, external_space_ram_pkg::STATUS_REG_ADDR, 32'h0);
        check(q, 32'h0000_0008);
        $display("flash steering test done");
        stop_test();
    end
endmodule
